// ---- rtl/odps_slave.sv ----
`timescale 1ns/1ps
module odps_slave
	import odps_pkg::*;
(
	input wire logic ref_clk, // Block clock, 200 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic pin_reset_n, // Hardware reset pin, active low.
	input wire logic pin_cs_n, // Select pin, active low.
	input wire logic pin_clk, // Link clock pin.
	input wire logic [7:0] dq_in, // Data lines, input side.
	output logic [7:0] dq_out, // Data lines, output side.
	output logic dq_oe, // Data lines driven.
	input wire logic strobe_mask_line_in, // Strobe pin, input side.
	output logic strobe_mask_line_out, // Strobe pin, output side.
	output logic strobe_mask_line_oe, // Strobe pin driven.
	input wire logic refresh_extra_latency, // Array asks for extra latency.
	input wire logic wrap_en, // Wrapped burst order when high.
	input wire logic [1:0] wrap_sel, // Wrap length 8, 16, 32 or 64 words.
	output logic rd_req, // Read word request pulse.
	output logic [ADDR_W-1:0] rd_addr, // Word address of the request.
	input wire logic [WORD_W-1:0] rd_data, // Read word.
	input wire logic rd_ack, // Read word valid pulse.
	output logic wr_valid, // Write word available.
	input wire logic wr_ready, // Write word taken.
	output logic [ADDR_W-1:0] wr_addr, // Write word address.
	output logic [WORD_W-1:0] wr_data, // Write word, first byte high.
	output logic [1:0] wr_mask, // Byte masks, high means keep.
	output logic wr_overrun, // Sticky: a write word was lost.
	output logic cmd_pulse, // Valid command received.
	output logic [7:0] cmd_code // Opcode of that command.
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic [PIN_W-1:0] pin_vec;
	logic [PIN_W-1:0] sync1;
	logic [PIN_W-1:0] sync2;
	logic [PIN_W-1:0] sync3;
	logic [PIN_W-1:0] acc;
	logic clk_prev;
	logic cs_prev_n;
	logic clk_rise;
	logic clk_fall;
	logic clk_edge;
	logic cs_fall;
	logic cs_n_s;
	logic hw_run;
	logic [7:0] dq_s;
	logic strobe_s;
	odps_state_t st;
	logic [2:0] ca_cnt;
	logic [23:0] ca_sh;
	logic [7:0] op;
	logic [ADDR_W-1:0] addr;
	logic [7:0] lat_cnt;
	logic refresh_lat;
	logic data_rise;
	logic data_fall;
	logic rd_go;
	logic rd_fall;
	logic wr_go;
	logic wr_fall;
	logic [WORD_W-1:0] rword;
	logic [7:0] lo_byte;
	logic [7:0] wr_hi;
	logic wr_hi_mask;
	logic push_valid;
	logic [FIFO_W-1:0] push_data;
	logic push_ready;
	logic [FIFO_W-1:0] pop_data;

	// Wrapped order stays inside an aligned block; linear just counts on.
	function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
		input logic wrap, input logic [1:0] sel);
		logic [ADDR_W-1:0] len_mask;
		logic [ADDR_W-1:0] inc;
		len_mask = (WRAP_BASE_WORDS << sel) - 32'h00000001;
		inc = a + 32'h00000001;
		if (wrap) begin
			return (a & ~len_mask) | (inc & len_mask);
		end
		return inc;
	endfunction

	assign pin_vec = {pin_reset_n, pin_cs_n, pin_clk, strobe_mask_line_in, dq_in};

	// Every pin passes three flops; a level counts once stages two and three agree.
	for (genvar g = 0; g < PIN_W; g++) begin : g_sync
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				sync1[g] <= PIN_RESET_VAL[g];
				sync2[g] <= PIN_RESET_VAL[g];
				sync3[g] <= PIN_RESET_VAL[g];
				acc[g] <= PIN_RESET_VAL[g];
			end else begin
				sync1[g] <= pin_vec[g];
				sync2[g] <= sync1[g];
				sync3[g] <= sync2[g];
				if (sync2[g] == sync3[g]) begin
					acc[g] <= sync3[g];
				end
			end
		end
	end

	assign dq_s = acc[PIN_DQ_LSB +: 8];
	assign strobe_s = acc[PIN_STROBE];
	assign cs_n_s = acc[PIN_CS];
	assign hw_run = acc[PIN_RST];

	// Edges are found from sampled levels, so a stopped clock simply yields none.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clk_prev <= 1'b0;
			cs_prev_n <= 1'b1;
		end else begin
			clk_prev <= acc[PIN_CLK];
			cs_prev_n <= cs_n_s;
		end
	end

	assign clk_rise = acc[PIN_CLK] && !clk_prev;
	assign clk_fall = !acc[PIN_CLK] && clk_prev;
	assign clk_edge = clk_rise || clk_fall;
	assign cs_fall = !cs_n_s && cs_prev_n;

	// The data edge of a latency period is the rising edge after its last counted one.
	assign data_rise = clk_rise && (st == ST_RDATA || st == ST_WDATA ||
		(st == ST_LAT && lat_cnt == 8'h00));
	assign data_fall = clk_fall && (st == ST_RDATA || st == ST_WDATA);
	assign rd_go = data_rise && odps_is_read(op);
	assign rd_fall = data_fall && st == ST_RDATA;
	assign wr_go = data_rise && !odps_is_read(op);
	assign wr_fall = data_fall && st == ST_WDATA;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= ST_IDLE;
			ca_cnt <= 3'h0;
			ca_sh <= 24'h000000;
			op <= 8'h00;
			addr <= 32'h00000000;
			lat_cnt <= 8'h00;
			refresh_lat <= 1'b0;
		end else if (!hw_run || cs_n_s) begin
			st <= ST_IDLE;
		end else if (cs_fall) begin
			st <= ST_CA;
			ca_cnt <= 3'h0;
			refresh_lat <= refresh_extra_latency;
		end else if (clk_edge) begin
			unique case (st)
				ST_IDLE, ST_DONE: begin
				end
				ST_CA: begin
					ca_sh <= {ca_sh[15:0], dq_s};
					ca_cnt <= ca_cnt + 3'h1;
					if (ca_cnt == CMD_LAST_EDGE) begin
						op <= dq_s;
						if (ca_sh[7:0] != dq_s || !odps_needs_addr(dq_s)) begin
							st <= ST_DONE;
						end
					end
					if (ca_cnt == CA_LAST_EDGE) begin
						addr <= {ca_sh, dq_s};
						if (odps_is_reg_write(op)) begin
							st <= ST_WDATA;
						end else begin
							st <= ST_LAT;
							lat_cnt <= refresh_lat ? {LAT_CYCLES[6:0], 1'b0} : LAT_CYCLES;
						end
					end
				end
				ST_LAT: begin
					if (clk_rise) begin
						if (lat_cnt == 8'h00) begin
							st <= odps_is_read(op) ? ST_RDATA : ST_WDATA;
						end else begin
							lat_cnt <= lat_cnt - 8'h01;
						end
					end
				end
				ST_RDATA, ST_WDATA: begin
					if (clk_fall) begin
						addr <= step_addr(addr, wrap_en, wrap_sel);
					end
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	// Next word is fetched on the falling data edge, once the current word's low byte is on the wires.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_req <= 1'b0;
			rd_addr <= 32'h00000000;
			rword <= 16'h0000;
		end else begin
			rd_req <= 1'b0;
			if (hw_run && !cs_n_s && st == ST_CA && clk_edge && ca_cnt == CA_LAST_EDGE &&
				odps_is_read(op)) begin
				rd_req <= 1'b1;
				rd_addr <= {ca_sh, dq_s};
			end else if (hw_run && !cs_n_s && rd_fall) begin
				rd_req <= 1'b1;
				rd_addr <= step_addr(addr, wrap_en, wrap_sel);
			end
			if (rd_ack) begin
				rword <= rd_data;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dq_out <= 8'h00;
			dq_oe <= 1'b0;
			strobe_mask_line_out <= 1'b0;
			strobe_mask_line_oe <= 1'b0;
			lo_byte <= 8'h00;
		end else if (!hw_run || cs_n_s) begin
			dq_out <= 8'h00;
			dq_oe <= 1'b0;
			strobe_mask_line_out <= 1'b0;
			strobe_mask_line_oe <= 1'b0;
		end else begin
			// In write data the host owns the strobe, so it is released there.
			strobe_mask_line_oe <= st == ST_CA ||
				(odps_is_read(op) && (st == ST_LAT || st == ST_RDATA));
			dq_oe <= st == ST_RDATA || rd_go;
			if (st == ST_CA) begin
				strobe_mask_line_out <= refresh_lat;
			end else if (rd_go) begin
				strobe_mask_line_out <= 1'b1;
				dq_out <= rword[15:8];
				lo_byte <= rword[7:0];
			end else if (rd_fall) begin
				strobe_mask_line_out <= 1'b0;
				dq_out <= lo_byte;
			end else if (st != ST_RDATA) begin
				strobe_mask_line_out <= 1'b0;
			end
		end
	end

	// The host cannot be stalled, so a full buffer costs the word and raises a flag.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_hi <= 8'h00;
			wr_hi_mask <= 1'b0;
			push_valid <= 1'b0;
			push_data <= '0;
			wr_overrun <= 1'b0;
			cmd_pulse <= 1'b0;
			cmd_code <= 8'h00;
		end else begin
			push_valid <= 1'b0;
			cmd_pulse <= 1'b0;
			if (hw_run && !cs_n_s && wr_go) begin
				wr_hi <= dq_s;
				wr_hi_mask <= strobe_s;
			end
			if (hw_run && !cs_n_s && wr_fall) begin
				push_valid <= 1'b1;
				push_data <= {addr, wr_hi, dq_s, wr_hi_mask, strobe_s};
			end
			if (push_valid && !push_ready) begin
				wr_overrun <= 1'b1;
			end
			if (hw_run && !cs_n_s && !cs_fall && st == ST_CA && clk_edge &&
				ca_cnt == CMD_LAST_EDGE && ca_sh[7:0] == dq_s) begin
				cmd_pulse <= 1'b1;
				cmd_code <= dq_s;
			end
		end
	end

	odps_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.clk(ref_clk),
		.rst(rst),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(pop_data)
	);

	assign wr_addr = pop_data[FIFO_W-1 -: ADDR_W];
	assign wr_data = pop_data[17:2];
	assign wr_mask = pop_data[1:0];

	sequence s_wr_word;
		wr_go && hw_run && !cs_n_s ##[1:40] (wr_fall && hw_run && !cs_n_s);
	endsequence

	sequence s_ca_end(logic reg_wr);
		st == ST_CA && clk_edge && ca_cnt == CA_LAST_EDGE && hw_run && !cs_n_s &&
			!cs_fall && odps_is_reg_write(op) == reg_wr;
	endsequence

	a_cs_ends_xfer: assert property (cs_n_s |=> st == ST_IDLE)
		else $error("select high did not return to idle");

	a_cmd_pair_check: assert property (st == ST_CA && clk_edge && ca_cnt == CMD_LAST_EDGE &&
		ca_sh[7:0] != dq_s && hw_run && !cs_n_s && !cs_fall |=> st == ST_DONE)
		else $error("mismatched opcode pair was accepted");

	a_ca_strobe_lat: assert property ($past(st) == ST_CA && $past(hw_run && !cs_n_s)
		|-> strobe_mask_line_oe && strobe_mask_line_out == $past(refresh_lat))
		else $error("strobe does not show refresh latency in command phase");

	a_reg_wr_nolat: assert property (s_ca_end(1'b1) |=> st == ST_WDATA)
		else $error("register write entered a latency period");

	a_lat_count: assert property (s_ca_end(1'b0) |=> st == ST_LAT &&
		lat_cnt == (refresh_lat ? {LAT_CYCLES[6:0], 1'b0} : LAT_CYCLES))
		else $error("latency count wrong for strobe state");

	a_rd_hi_first: assert property (rd_go && hw_run && !cs_n_s |=> dq_oe &&
		strobe_mask_line_out && dq_out == $past(rword[15:8]) ##0 dq_oe)
		else $error("read word high byte not driven with strobe rise");

	a_wr_word_push: assert property (s_wr_word |=> push_valid &&
		push_data[0] == $past(strobe_s) && push_data[9:2] == $past(dq_s))
		else $error("write word not pushed with its mask");

	a_reset_hiz: assert property (!hw_run |=> !dq_oe && !strobe_mask_line_oe)
		else $error("lines driven during hardware reset");

	a_dq_read_only: assert property (st != ST_RDATA && !rd_go |=> !dq_oe)
		else $error("data lines driven outside read data");
endmodule // odps_slave

// ---- rtl/odps_pkg.sv ----
package odps_pkg;

	// Pin sampling vector layout.
	localparam int PIN_W = 12;
	localparam int PIN_DQ_LSB = 0;
	localparam int PIN_STROBE = 8;
	localparam int PIN_CLK = 9;
	localparam int PIN_CS = 10;
	localparam int PIN_RST = 11;
	// Select idles high, hardware reset is taken as asserted until seen high.
	localparam logic [PIN_W-1:0] PIN_RESET_VAL = 12'h400;

	// Opcodes the front end decodes.
	localparam logic [7:0] OP_READ = 8'hee;
	localparam logic [7:0] OP_WRITE = 8'hde;
	localparam logic [7:0] OP_REG_READ = 8'h65;
	localparam logic [7:0] OP_REG_WRITE = 8'h71;
	localparam logic [7:0] OP_READ_ID = 8'h9f;

	// Command/address phase: one command cycle plus two address cycles.
	localparam logic [2:0] CA_LAST_EDGE = 3'h5;
	localparam logic [2:0] CMD_LAST_EDGE = 3'h1;
	// Latency count in link cycles; plain default.
	localparam logic [7:0] LAT_CYCLES = 8'h04;
	localparam logic [31:0] WRAP_BASE_WORDS = 32'h00000008;

	localparam int ADDR_W = 32;
	localparam int WORD_W = 16;
	localparam int FIFO_W = ADDR_W + WORD_W + 2;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CA,
		ST_LAT,
		ST_RDATA,
		ST_WDATA,
		ST_DONE
	} odps_state_t;

	function automatic logic odps_needs_addr(input logic [7:0] op);
		return (op == OP_READ) || (op == OP_WRITE) || (op == OP_REG_READ) ||
			(op == OP_REG_WRITE) || (op == OP_READ_ID);
	endfunction

	function automatic logic odps_is_read(input logic [7:0] op);
		return (op == OP_READ) || (op == OP_REG_READ) || (op == OP_READ_ID);
	endfunction

	function automatic logic odps_is_reg_write(input logic [7:0] op);
		return op == OP_REG_WRITE;
	endfunction

endpackage

// ---- rtl/odps_fifo.sv ----
`timescale 1ns/1ps
module odps_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk, // Block clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic in_valid, // Word offered.
	output logic in_ready, // Space available.
	input wire logic [WIDTH-1:0] in_data, // Word in.
	output logic out_valid, // Word available.
	input wire logic out_ready, // Drain side accepts.
	output logic [WIDTH-1:0] out_data // Word out.
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic [AW:0] next_wr_ptr;
	logic [AW:0] next_rd_ptr;
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty = wr_ptr == rd_ptr;
	assign in_ready = !full;
	assign push = in_valid && !full;
	assign pop = out_ready && !empty;
	assign next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
	assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

	// The head word is registered so the drain side only ever sees flop outputs.
	// A word written into the slot that becomes the head bypasses the array.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
		if (push && wr_ptr[AW-1:0] == next_rd_ptr[AW-1:0]) begin
			out_data <= in_data;
		end else begin
			out_data <= mem[next_rd_ptr[AW-1:0]];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			out_valid <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			out_valid <= next_wr_ptr != next_rd_ptr;
		end
	end
endmodule // odps_fifo

// ---- verif/odps_host_model.sv ----
`timescale 1ns/1ps
module odps_host_model
	import odps_pkg::*;
(
	output logic cs_n, // Select, active low.
	output logic clk, // Link clock, idle low.
	output logic [7:0] dq, // Data drive value.
	output logic dq_oe, // Host drives data.
	output logic strb, // Mask drive value.
	output logic strb_oe, // Host drives strobe.
	input wire logic strb_in // Resolved strobe line.
);
	logic [17:0] wq[$];
	logic extra = 1'b0;
	int rises = 0;
	initial begin
		cs_n = 1'b1;
		clk = 1'b0;
		dq = 8'h00;
		dq_oe = 1'b0;
		strb = 1'b0;
		strb_oe = 1'b0;
	end
	// Lines move long after the previous edge, since the device sees edges late.
	task automatic half(input logic [7:0] d, input logic doe, input logic moe, input logic m);
		#18;
		dq = d;
		dq_oe = doe;
		strb = m;
		strb_oe = moe;
		#6;
		clk = ~clk;
		if (clk)
			rises++;
	endtask
	task automatic frame(input logic [7:0] op0, input logic [7:0] op1, input logic [31:0] a,
		input logic lat_on, input int n, input logic wr);
		logic [17:0] w;
		int lat;
		cs_n = 1'b0;
		#24;
		half(op0, 1'b1, 1'b0, 1'b0);
		half(op1, 1'b1, 1'b0, 1'b0);
		for (int i = 3; i >= 0; i--)
			half(a[8*i+:8], 1'b1, 1'b0, 1'b0);
		extra = strb_in;
		rises = 0;
		lat = lat_on ? (extra ? 2 : 1) * LAT_CYCLES : 0;
		for (int i = 0; i < 2 * lat; i++)
			half(8'h00, 1'b0, 1'b0, 1'b0);
		// The device lets go of the strobe some cycles after it sees the last command edge.
		// With no latency the clock therefore stands still before the first mask is driven.
		if (wr && lat == 0)
			#24;
		for (int i = 0; i < n; i++) begin
			w = wr ? wq.pop_front() : 18'h00000;
			half(w[15:8], wr, wr, w[17]);
			half(w[7:0], wr, wr, w[16]);
		end
		#18;
		dq_oe = 1'b0;
		strb_oe = 1'b0;
		#60;
		cs_n = 1'b1;
		#60;
	endtask
endmodule // odps_host_model

// ---- verif/test_octal_ddr_psram_bus_slave.sv ----
`timescale 1ns/1ps
module test_octal_ddr_psram_bus_slave;
	import odps_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic pin_reset_n = 1'b1;
	logic refresh_extra_latency = 1'b0;
	logic wrap_en = 1'b0;
	logic [1:0] wrap_sel = 2'h0;
	logic [WORD_W-1:0] rd_data = 16'h0000;
	logic rd_ack = 1'b0;
	logic wr_ready = 1'b0;
	logic drain = 1'b1;
	logic h_cs_n, h_clk, h_dq_oe, h_strb, h_strb_oe;
	logic [7:0] h_dq, dq_out, dq_line, cmd_code, last_cmd;
	logic [7:0] dq_prev = 8'h00;
	logic strobe_prev = 1'b0;
	logic dq_oe, strobe_line, strobe_out, strobe_oe, rd_req, wr_valid, wr_overrun, cmd_pulse;
	logic [ADDR_W-1:0] rd_addr, wr_addr;
	logic [WORD_W-1:0] wr_data;
	logic [1:0] wr_mask;
	logic [7:0] rq[$];
	logic [49:0] wseen[$];
	int mismatches = 0;
	int comparisons = 0;
	int ncmd = 0;
	int lat_seen = 0;
	logic p_oe = 1'b0;
	logic p_st = 1'b0;

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	// A released line shows a changing pattern so a stale value never passes.
	assign dq_line = dq_oe ? dq_out : (h_dq_oe ? h_dq : ~dq_prev);
	assign strobe_line = strobe_oe ? strobe_out : (h_strb_oe ? h_strb : ~strobe_prev);

	odps_slave odps_slave_inst (.ref_clk(ref_clk), .rst(rst), .pin_reset_n(pin_reset_n),
		.pin_cs_n(h_cs_n), .pin_clk(h_clk), .dq_in(dq_line), .dq_out(dq_out), .dq_oe(dq_oe),
		.strobe_mask_line_in(strobe_line), .strobe_mask_line_out(strobe_out),
		.strobe_mask_line_oe(strobe_oe), .refresh_extra_latency(refresh_extra_latency),
		.wrap_en(wrap_en), .wrap_sel(wrap_sel), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_data(rd_data), .rd_ack(rd_ack), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_addr(wr_addr), .wr_data(wr_data), .wr_mask(wr_mask), .wr_overrun(wr_overrun),
		.cmd_pulse(cmd_pulse), .cmd_code(cmd_code));
	odps_host_model odps_host_model_inst (.cs_n(h_cs_n), .clk(h_clk), .dq(h_dq),
		.dq_oe(h_dq_oe), .strb(h_strb), .strb_oe(h_strb_oe), .strb_in(strobe_line));

	function automatic logic [15:0] word_of(input logic [31:0] a);
		return a[15:0] ^ {a[23:16], a[31:24]} ^ 16'h3c96;
	endfunction
	function automatic logic [31:0] nxt(input logic [31:0] a);
		logic [31:0] m;
		m = (WRAP_BASE_WORDS << wrap_sel) - 32'h00000001;
		return wrap_en ? ((a & ~m) | ((a + 32'h00000001) & m)) : a + 32'h00000001;
	endfunction

	always @(posedge ref_clk) begin
		dq_prev <= dq_line;
		strobe_prev <= strobe_line;
		if (dq_oe === 1'b1 && (p_oe !== 1'b1 || strobe_out !== p_st))
			rq.push_back(dq_out);
		if (dq_oe === 1'b1 && p_oe !== 1'b1)
			lat_seen = odps_host_model_inst.rises;
		p_oe <= dq_oe;
		p_st <= strobe_out;
		if (cmd_pulse === 1'b1) begin
			ncmd++;
			last_cmd = cmd_code;
		end
		if (wr_valid === 1'b1 && wr_ready === 1'b1)
			wseen.push_back({wr_mask, wr_data, wr_addr});
	end
	always @(negedge ref_clk) begin
		rd_ack <= rd_req;
		if (rd_req === 1'b1)
			rd_data <= word_of(rd_addr);
		wr_ready <= drain && ($urandom % 3 != 0);
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic setup(input logic refr, input logic wen, input logic [1:0] wsel);
		@(negedge ref_clk);
		refresh_extra_latency = refr;
		wrap_en = wen;
		wrap_sel = wsel;
	endtask
	task automatic read_test(input logic [7:0] op, input logic [31:0] a, input int n);
		int c0;
		logic [31:0] e;
		logic [15:0] w;
		c0 = ncmd;
		e = a;
		rq.delete();
		odps_host_model_inst.frame(op, op, a, 1'b1, n, 1'b0);
		check(ncmd, c0 + 1, "command count");
		check(last_cmd, op, "command code");
		check(odps_host_model_inst.extra, refresh_extra_latency, "refresh strobe");
		check(lat_seen, (refresh_extra_latency ? 2 : 1) * LAT_CYCLES + 1, "latency");
		check(rq.size(), 2 * n, "byte count");
		for (int i = 0; i < n; i++) begin
			w = word_of(e);
			check(rq[2*i], w[15:8], "first byte");
			check(rq[2*i+1], w[7:0], "second byte");
			e = nxt(e);
		end
		check({dq_oe, strobe_oe}, 2'b00, "lines released");
		$display("read test done");
	endtask
	task automatic write_test(input logic [7:0] op, input logic [31:0] a, input int n);
		logic [49:0] exp[$];
		logic [17:0] w;
		logic [31:0] e;
		e = a;
		wseen.delete();
		for (int i = 0; i < n; i++) begin
			w = 18'($urandom);
			odps_host_model_inst.wq.push_back(w);
			if (i < FIFO_DEPTH || drain)
				exp.push_back({w, e});
			e = nxt(e);
		end
		odps_host_model_inst.frame(op, op, a, op == OP_WRITE, n, 1'b1);
		check(wr_overrun, n > FIFO_DEPTH && !drain, "overrun flag");
		@(posedge ref_clk);
		drain = 1'b1;
		repeat (40) @(posedge ref_clk);
		check(odps_host_model_inst.extra, refresh_extra_latency, "refresh strobe");
		check(wseen.size(), exp.size(), "word count");
		foreach (exp[i])
			check(wseen[i], exp[i], "written word");
		$display("write test done");
	endtask

	initial begin
		int c0;
		void'($urandom(85867));
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		repeat (8) @(negedge ref_clk);
		// Random gaps are not added: the link clock already stands still between frames.
		for (int k = 0; k < 6; k++) begin
			setup(k == 0 || (k != 2 && $urandom % 2), k == 1 || (k > 2 && $urandom % 2),
				k == 1 ? 2'h0 : 2'($urandom));
			read_test(k % 3 == 0 ? OP_READ : (k % 3 == 1 ? OP_REG_READ : OP_READ_ID),
				k == 0 ? 32'h0000fffe : (k == 1 ? 32'h00000106 : $urandom), 1 + $urandom % 9);
			write_test(k % 2 ? OP_REG_WRITE : OP_WRITE, $urandom, k % 2 ? 1 : 1 + $urandom % 8);
		end
		rq.delete();
		c0 = ncmd;
		odps_host_model_inst.frame(OP_READ, OP_WRITE, $urandom, 1'b0, 2, 1'b0);
		check(ncmd, c0, "refused command");
		check(rq.size(), 0, "no read data");
		c0 = ncmd;
		odps_host_model_inst.frame(8'h3a, 8'h3a, $urandom, 1'b0, 2, 1'b0);
		check(ncmd, c0 + 1, "lone command count");
		check(last_cmd, 8'h3a, "lone command code");
		check(rq.size(), 0, "no lone command data");
		$display("refusal test done");
		@(posedge ref_clk);
		drain = 1'b0;
		write_test(OP_WRITE, $urandom, FIFO_DEPTH + 2);
		@(negedge ref_clk);
		rst = 1'b1;
		@(negedge ref_clk);
		rst = 1'b0;
		repeat (8) @(negedge ref_clk);
		check(wr_overrun, 1'b0, "overrun cleared");
		fork
			odps_host_model_inst.frame(OP_READ, OP_READ, $urandom, 1'b1, 6, 1'b0);
			begin
				wait (dq_oe === 1'b1);
				@(negedge ref_clk);
				pin_reset_n = 1'b0;
				repeat (6) @(negedge ref_clk);
				check({dq_oe, strobe_oe}, 2'b00, "hardware reset");
				pin_reset_n = 1'b1;
			end
		join
		$display("hardware reset test done");
		tally_and_finish();
	end
	// Sixteen frames of about a microsecond each fit many times over.
	initial begin
		#200000;
		mismatches++;
		tally_and_finish();
	end
endmodule // test_octal_ddr_psram_bus_slave
